// ---- core/pcstk_top.sv ----
// Function
// - program counter is 13 bits, covering an 8K by 14 program space.
// - fetch addresses above the 1K or 2K implemented space wrap around.
// - reset starts at address zero; an accepted interrupt goes to four.
// - bank select bit one picks data bank 1, zero picks bank 0.
// - each bank spans up to 7Fh, registers low, static RAM above.
// - addresses F0h to FFh reach bank 0 locations 70h to 7Fh.
// - low counter byte is a register; upper five bits come via latch.
// - any reset clears the whole program counter.
// - writing the low register loads upper bits from latch bits 4:0.
// - call or jump takes top two bits from latch bits 4:3.
// - eight-entry, 13-bit return stack with a hidden pointer.
// - call or accepted interrupt pushes the counter.
// - any of the three return kinds pops into the counter.
// - push and pop leave the high latch untouched.
// - stack is circular; the ninth push overwrites the first.
// - no overflow or underflow indication exists.
// - latch paging bits are ignored when forming fetch addresses.
//
// Purpose: program sequencing and data bank selection for an 8-bit core
// Assumes: core events are one-cycle pulses, at most one per cycle
// Notes: interrupt, jump, call and return win over a same-cycle apb write to the low register; fetch advance loses to it
//
// The placing of the registers and the APB register port were left to the implementer.
module pcstk_top
   import pcstk_pkg::*;
(
   input wire logic pclk, // core clock, 125 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic fetch_adv, // instruction fetched, advance
   input wire logic jump_instr, // jump taken
   input wire logic call_instr, // call taken
   input wire logic [TARGET_W-1:0] jump_target, // target from opcode
   input wire logic ret_instr, // any return kind executes
   input wire logic int_accept, // interrupt accepted
   input wire logic [FILE_W-1:0] file_addr, // direct data address
   output logic [PC_W-1:0] fetch_addr, // wrapped program address
   output logic [PC_W-1:0] program_counter, // full counter
   output logic [DADDR_W-1:0] data_addr // physical data address
);

   pcstk_apb_type apb_state_r;
   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] pc_nxt;
   logic [HIGH_W-1:0] pc_high_latch_r;
   logic [7:0] status_r;
   logic cfg_2k_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [PC_W-1:0] fetch_addr_r;
   logic [DADDR_W-1:0] data_addr_r;
   logic [PC_W-1:0] stack_top;
   logic [PC_W-1:0] push_value;
   logic stack_push;
   logic stack_pop;
   logic wr_fire;
   logic setup;

   // ==========================================================
   // decode helpers
   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == OFF_PC_LOW) || (a == OFF_PC_HIGH_LATCH) ||
                   (a == OFF_STATUS) || (a == OFF_CONFIG);
   endfunction : addr_known

   function automatic logic [PC_W-1:0] wrap_fetch(
      input logic [PC_W-1:0] pc,
      input logic size_2k
   );
      // upper bits, paging bits included, simply drop out here
      wrap_fetch = pc & (size_2k ? MASK_2K : MASK_1K);
   endfunction : wrap_fetch

   function automatic logic [DADDR_W-1:0] map_data(
      input logic bank,
      input logic [FILE_W-1:0] fa
   );
      // top sixteen bytes are shared so isr code needs no bank switch
      if (fa >= COMMON_BASE)
         map_data = {1'b0, fa};
      else
         map_data = {bank, fa};
   endfunction : map_data

   // ==========================================================
   // apb slave: fixed one access cycle, ready from a flop
   assign setup = psel && !penable;
   assign wr_fire = psel && penable && pready_r && pwrite && !pslverr_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         apb_state_r <= PCSTK_IDLE;
      else
      begin
         case (apb_state_r)
            PCSTK_IDLE:
            begin
               if (setup)
                  apb_state_r <= PCSTK_ACCESS;
            end
            PCSTK_ACCESS:
            begin
               apb_state_r <= PCSTK_IDLE;
            end
            default:
            begin
               apb_state_r <= PCSTK_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready_r <= 1'b0;
      else
         pready_r <= (apb_state_r == PCSTK_IDLE) && setup;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr_r <= 1'b0;
      else if ((apb_state_r == PCSTK_IDLE) && setup)
         pslverr_r <= !addr_known(paddr);
      else
         pslverr_r <= 1'b0;
   end

   // read data captured in setup, stable through the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_r <= 32'h0000_0000;
      else if ((apb_state_r == PCSTK_IDLE) && setup && !pwrite)
      begin
         case (paddr)
            OFF_PC_LOW:
               prdata_r <= {24'h00_0000, pc_r[LOW_W-1:0]};
            OFF_PC_HIGH_LATCH:
               prdata_r <= {27'h000_0000, pc_high_latch_r};
            OFF_STATUS:
               prdata_r <= {24'h00_0000, status_r};
            OFF_CONFIG:
               prdata_r <= {31'h0000_0000, cfg_2k_r};
            default:
               prdata_r <= 32'h0000_0000;
         endcase
      end
      else if (apb_state_r == PCSTK_ACCESS)
         prdata_r <= 32'h0000_0000;
   end

   // ==========================================================
   // software registers
   // latch only moves on software writes, never on push or pop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pc_high_latch_r <= LATCH_RESET;
      else if (wr_fire && (paddr == OFF_PC_HIGH_LATCH) && pstrb[0])
         pc_high_latch_r <= pwdata[HIGH_W-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_r <= STATUS_RESET;
      else if (wr_fire && (paddr == OFF_STATUS) && pstrb[0])
         status_r <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_2k_r <= CFG_SIZE_RESET;
      else if (wr_fire && (paddr == OFF_CONFIG) && pstrb[0])
         cfg_2k_r <= pwdata[CFG_SIZE_POS];
   end

   // ==========================================================
   // return stack
   assign stack_push = int_accept || (call_instr && !int_accept);
   assign stack_pop = ret_instr && !int_accept && !call_instr &&
                      !jump_instr;
   // interrupt resumes the interrupted instruction, call the next one
   assign push_value = int_accept ? pc_r : pc_r + 13'h0001;

   pcstk_ret_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(PC_W)
   ) u_pcstk_ret_stack (
      .pclk(pclk),
      .presetn(presetn),
      .push(stack_push),
      .pop(stack_pop),
      .push_data(push_value),
      .top_data(stack_top)
   );

   // ==========================================================
   // program counter next value, interrupt first
   always_comb
   begin
      pc_nxt = pc_r;
      if (int_accept)
         pc_nxt = INT_VECTOR;
      else if (call_instr || jump_instr)
         pc_nxt = {pc_high_latch_r[4:3], jump_target};
      else if (ret_instr)
         pc_nxt = stack_top;
      else if (wr_fire && (paddr == OFF_PC_LOW) && pstrb[0])
         // no carry from the low byte into the upper part
         pc_nxt = {pc_high_latch_r, pwdata[LOW_W-1:0]};
      else if (fetch_adv)
         pc_nxt = pc_r + 13'h0001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pc_r <= RESET_VECTOR;
      else
         pc_r <= pc_nxt;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fetch_addr_r <= RESET_VECTOR;
      else
         fetch_addr_r <= wrap_fetch(pc_nxt, cfg_2k_r);
   end

   // ==========================================================
   // data memory mapping, one cycle behind file_addr
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         data_addr_r <= 8'h00;
      else
         data_addr_r <= map_data(status_r[BANK_SELECT_POS], file_addr);
   end

   // ==========================================================
   // outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign program_counter = pc_r;
   assign fetch_addr = fetch_addr_r;
   assign data_addr = data_addr_r;

endmodule : pcstk_top

// ---- core/pcstk_pkg.sv ----
// Purpose: shared constants for the program counter and return stack block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: all offsets are byte addresses
package pcstk_pkg;

   // ==========================================================
   // widths
   localparam int PC_W = 13;
   localparam int LOW_W = 8;
   localparam int HIGH_W = 5;
   localparam int STACK_DEPTH = 8;
   localparam int PTR_W = 3;
   localparam int FILE_W = 7;
   localparam int DADDR_W = 8;
   localparam int TARGET_W = 11;

   // ==========================================================
   // register offsets
   localparam logic [7:0] OFF_PC_LOW = 8'h00;
   localparam logic [7:0] OFF_PC_HIGH_LATCH = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_CONFIG = 8'h0c;

   // ==========================================================
   // field positions and reset values
   localparam int BANK_SELECT_POS = 5;
   localparam int CFG_SIZE_POS = 0;
   localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
   localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
   localparam logic [PC_W-1:0] MASK_1K = 13'h03ff;
   localparam logic [PC_W-1:0] MASK_2K = 13'h07ff;
   localparam logic [HIGH_W-1:0] LATCH_RESET = 5'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic CFG_SIZE_RESET = 1'b0;
   localparam logic [FILE_W-1:0] COMMON_BASE = 7'h70;

   // ==========================================================
   // apb phase
   typedef enum logic [1:0]
   {
      PCSTK_IDLE = 2'b01,
      PCSTK_ACCESS = 2'b10
   } pcstk_apb_type;

endpackage : pcstk_pkg

// ---- core/pcstk_ret_stack.sv ----
// Purpose: eight-entry circular return stack
// Assumes: push and pop never in the same cycle
// Notes: pointer is internal only, no overflow or underflow report
module pcstk_ret_stack
   import pcstk_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH,
   parameter int WIDTH = PC_W
)
(
   input wire logic pclk, // core clock
   input wire logic presetn, // async reset, active low
   input wire logic push, // store push_data on top
   input wire logic pop, // remove top entry
   input wire logic [WIDTH-1:0] push_data, // value to push
   output logic [WIDTH-1:0] top_data // current top entry
);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PTR_W-1:0] ptr_r;

   // ==========================================================
   // pointer wraps freely; the ninth push lands on the first slot
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ptr_r <= '0;
      else if (push)
         ptr_r <= ptr_r + 3'h1;
      else if (pop)
         ptr_r <= ptr_r - 3'h1;
   end

   always_ff @(posedge pclk)
   begin
      if (push)
         mem_r[ptr_r] <= push_data;
   end

   // no flag: underflow just reads an older slot
   assign top_data = mem_r[ptr_r - 3'h1];

endmodule : pcstk_ret_stack

// ---- testbench/pcstk_top_assertions.sv ----
// Purpose: port-level checks of the sequencing block
// Assumes: one clock, async active-low reset
// Notes: bound from the testbench top file
module pcstk_top_assertions
   import pcstk_pkg::*;
(
   input wire logic pclk, // clock
   input wire logic presetn, // reset
   input wire logic psel, // select
   input wire logic penable, // enable
   input wire logic pready, // ready
   input wire logic fetch_adv, // advance
   input wire logic jump_instr, // jump
   input wire logic call_instr, // call
   input wire logic [TARGET_W-1:0] jump_target, // target
   input wire logic ret_instr, // return
   input wire logic int_accept, // interrupt
   input wire logic [FILE_W-1:0] file_addr, // data address in
   input wire logic [PC_W-1:0] fetch_addr, // fetch address
   input wire logic [PC_W-1:0] program_counter, // counter
   input wire logic [DADDR_W-1:0] data_addr // data address out
);
   // ==========================================================
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic ev;
   logic ret_only;
   assign ev = jump_instr | call_instr | ret_instr | int_accept;
   assign ret_only = ret_instr & ~(jump_instr | call_instr | int_accept);
   chk_reset_start: assert property ($rose(presetn) |->
      program_counter == RESET_VECTOR) else $error("counter not cleared");
   chk_int_vector: assert property (int_accept |=>
      program_counter == INT_VECTOR) else $error("no interrupt vector");
   chk_jump_target: assert property ((jump_instr | call_instr)
      && !int_accept |=> program_counter[TARGET_W-1:0] == $past(jump_target))
      else $error("jump target not loaded");
   chk_fetch_wrap: assert property (fetch_addr[12:11] == 2'b00 &&
      fetch_addr[9:0] == program_counter[9:0]) else $error("fetch not wrapped");
   chk_fetch_step: assert property (fetch_adv && !ev && !psel |=>
      program_counter == $past(program_counter) + 13'h1)
      else $error("counter did not advance");
   chk_call_return: assert property (call_instr && !int_accept ##1
      ret_only |=> program_counter == $past(program_counter, 2) + 13'h1)
      else $error("return address wrong");
   chk_common_ram: assert property (file_addr >= COMMON_BASE |=>
      data_addr == {1'b0, $past(file_addr)}) else $error("common ram wrong");
   chk_bank_offset: assert property ($past(presetn) |->
      data_addr[6:0] == $past(file_addr)) else $error("data offset wrong");
   chk_ready_pulse: assert property (psel && !penable |=>
      pready ##1 !pready) else $error("ready not one cycle");
endmodule : pcstk_top_assertions

// ---- testbench/pcstk_core_model.sv ----
// Purpose: execution core stand-in, one event per cycle
// Assumes: op changes just after a rising edge
// Notes: target lines are scrambled outside jump and call
module pcstk_core_model
   import pcstk_pkg::*;
(
   input wire logic [2:0] op, // 1 fetch 2 jump 3 call 4 ret 5 int
   input wire logic [TARGET_W-1:0] tgt, // opcode target
   output logic fetch_adv, // advance
   output logic jump_instr, // jump
   output logic call_instr, // call
   output logic ret_instr, // return
   output logic int_accept, // interrupt
   output logic [TARGET_W-1:0] jump_target // target
);
   // ==========================================================
   // decode
   assign fetch_adv = (op == 3'h1);
   assign jump_instr = (op == 3'h2);
   assign call_instr = (op == 3'h3);
   assign ret_instr = (op == 3'h4);
   assign int_accept = (op == 3'h5);
   assign jump_target = (op == 3'h2 || op == 3'h3) ? tgt : ~tgt;
endmodule : pcstk_core_model

// ---- testbench/program_counter_stack_tb.sv ----
// Purpose: self-checking bench for the sequencing block
// Assumes: zero-wait apb slave, one core event per cycle
// Notes: fixed seed, random targets and data addresses
module program_counter_stack_tb
   import pcstk_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, fetch_adv, jump_instr, call_instr, ret_instr, er;
   logic int_accept;
   logic [2:0] op = 3'h0;
   logic [TARGET_W-1:0] tgt = 11'h000, jt, t;
   logic [FILE_W-1:0] file_addr = 7'h00;
   logic [PC_W-1:0] fetch_addr, program_counter, epc, mask = MASK_1K;
   logic [DADDR_W-1:0] data_addr;
   logic [PC_W-1:0] stk[$];
   int errors = 0, total_checks = 0;
   always #4 pclk = ~pclk;
   pcstk_top u_pcstk_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .fetch_adv,
      .jump_instr, .call_instr, .jump_target(jt), .ret_instr, .int_accept,
      .file_addr, .fetch_addr, .program_counter, .data_addr);
   pcstk_core_model u_pcstk_core_model (.op, .tgt, .fetch_adv, .jump_instr,
      .call_instr, .ret_instr, .int_accept, .jump_target(jt));
   // ==========================================================
   // tasks
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // request holds until pready is seen high at a rising edge
      while (pready !== 1'b1 && n < 16)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 16) errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never re-raises psel at once
      @(posedge pclk);
   endtask : apb
   task automatic ev(input logic [2:0] o, input logic [TARGET_W-1:0] x);
      op <= o;
      tgt <= x;
      @(posedge pclk);
   endtask : ev
   task automatic pc_chk();
      op <= 3'h0;
      @(negedge pclk);
      chk("program_counter", 32'(epc), 32'(program_counter));
      chk("fetch_addr", 32'(epc & mask), 32'(fetch_addr));
      @(posedge pclk);
   endtask : pc_chk
   function automatic logic [7:0] dexp(logic b, logic [FILE_W-1:0] f);
      return (f >= COMMON_BASE) ? {1'b0, f} : {b, f};
   endfunction : dexp
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   // ==========================================================
   // sequence
   initial
   begin
      #40000;
      errors++;
      end_of_test();
   end
   initial
   begin
      int k;
      logic b;
      logic [FILE_W-1:0] f;
      void'($urandom(32'h1e0b4a6a));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      epc = RESET_VECTOR;
      pc_chk();
      k = 3 + $urandom % 6;
      repeat (k) ev(3'h1, 11'h000);
      epc = epc + 13'(k);
      pc_chk();
      $display("test reset and advance done");
      apb(1'b1, OFF_PC_HIGH_LATCH, 32'h1f);
      k = $urandom % 256;
      apb(1'b1, OFF_PC_LOW, 32'(k));
      epc = {5'h1f, 8'(k)};
      pc_chk();
      apb(1'b0, OFF_PC_LOW, 32'h0);
      chk("pc_low", 32'(k), rd);
      apb(1'b1, OFF_CONFIG, 32'h1);
      mask = MASK_2K;
      ev(3'h1, 11'h000);
      epc = epc + 13'h1;
      pc_chk();
      t = $urandom;
      ev(3'h2, t);
      epc = {2'b11, t};
      pc_chk();
      for (int i = 0; i < 9; i++)
      begin
         stk.push_front(epc + 13'h1);
         t = $urandom;
         ev(3'h3, t);
         epc = {2'b11, t};
      end
      for (int i = 0; i < 9; i++)
      begin
         ev(3'h4, 11'h000);
         epc = stk[i % 8];
         pc_chk();
      end
      apb(1'b0, OFF_PC_HIGH_LATCH, 32'h0);
      chk("high_latch", 32'h1f, rd);
      $display("test jump and stack done");
      k = 32'(epc);
      ev(3'h5, 11'h000);
      epc = INT_VECTOR;
      pc_chk();
      ev(3'h4, 11'h000);
      epc = 13'(k);
      pc_chk();
      for (int i = 0; i < 12; i++)
      begin
         b = 1'($urandom);
         f = (i == 0) ? 7'h6f : (i == 1) ? 7'h70 : 7'($urandom);
         apb(1'b1, OFF_STATUS, 32'(b) << BANK_SELECT_POS);
         file_addr <= f;
         @(posedge pclk);
         @(negedge pclk);
         chk("data_addr", 32'(dexp(b, f)), 32'(data_addr));
         @(posedge pclk);
      end
      // reset in mid-run must clear a counter that is far from zero
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      epc = RESET_VECTOR;
      mask = MASK_1K;
      pc_chk();
      apb(1'b0, 8'h10, 32'h0);
      chk("pslverr", 32'h1, 32'(er));
      chk("unmapped_read", 32'h0, rd);
      $display("test interrupt and data map done");
      end_of_test();
   end
endmodule : program_counter_stack_tb
bind pcstk_top pcstk_top_assertions u_pcstk_top_assertions (.pclk, .presetn,
   .psel, .penable, .pready, .fetch_adv, .jump_instr, .call_instr,
   .jump_target, .ret_instr, .int_accept, .file_addr, .fetch_addr,
   .program_counter, .data_addr);
